//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, reg_write, reg_read, zc_pin_sinking, zc_fuse_enable;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic zc_detector_on, zc_logic_output, zc_irq;
    int err_total = 0;
    int n_checks = 0;
    zcdc_top uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .zc_pin_sinking(zc_pin_sinking),
        .zc_fuse_enable(zc_fuse_enable), .zc_detector_on(zc_detector_on),
        .zc_logic_output(zc_logic_output), .zc_irq(zc_irq));
    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict and bus helpers
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input string w, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(w, e, reg_rdata);
    endtask : rd
    // Pin change, then enough cycles for output and flag to settle
    task automatic pin(input logic v);
        @(posedge clk);
        zc_pin_sinking <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask : pin
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(4'h0, "ctrl_rst", 8'h00);
        wr(4'h0, 8'hff);
        pin(1'b0);
        rd(4'h0, "ctrl_ff", 8'hb3);
        wr(4'h0, 8'h20);
        rd(4'h0, "ctrl_ro", 8'h00);
        chk("det_off", 8'h00, {7'h0, zc_detector_on});
        rd(4'h9, "unmapped", 8'h00);
        @(posedge clk);
        zc_fuse_enable <= 1'b1;
        wr(4'h0, 8'h10);
        pin(1'b0);
        chk("fuse_on", 8'h01, {7'h0, zc_logic_output});
        @(posedge clk);
        zc_fuse_enable <= 1'b0;
    endtask : t_regs
    task automatic t_pol();
        wr(4'h0, 8'h80);
        pin(1'b1);
        rd(4'h0, "sink_p0", 8'ha0);
        pin(1'b0);
        chk("src_p0", 8'h00, {7'h0, zc_logic_output});
        wr(4'h0, 8'h90);
        pin(1'b0);
        rd(4'h0, "src_p1", 8'hb0);
        pin(1'b1);
        chk("sink_p1", 8'h00, {7'h0, zc_logic_output});
    endtask : t_pol
    // Output now 0 (pol 1, sinking); pol 0 raises it before the clear
    task automatic t_edge();
        wr(4'h0, 8'h82);
        wr(4'h2, 8'h01);
        rd(4'h2, "int_en", 8'h01);
        wr(4'h3, 8'h01);
        pin(1'b0);
        rd(4'h1, "fall_ign", 8'h00);
        pin(1'b1);
        rd(4'h1, "rise_set", 8'h01);
        chk("irq_on", 8'h01, {7'h0, zc_irq});
        wr(4'h2, 8'h00);
        #1 chk("irq_mask", 8'h00, {7'h0, zc_irq});
        wr(4'h3, 8'h01);
        wr(4'h0, 8'h81);
        rd(4'h1, "clr", 8'h00);
        pin(1'b0);
        rd(4'h1, "fall_set", 8'h01);
    endtask : t_edge
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: 20 cycles of reset, then each scenario
    initial begin
        nrst = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        zc_pin_sinking = 1'b0;
        zc_fuse_enable = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_pol();
        t_edge();
        end_of_test();
    end
    // Watchdog well past the hundred or so cycles the run needs
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : tb_top

//--- inc/zcdc_pkg.sv
// What this block does
// - Bit 5 reads detector output state; read-only, writes ignored.
// - Polarity clear: status reads 1 while pin sinks, 0 while sourcing.
// - Polarity set: logic output inverted, status 1 while pin sources.
// - Falling edge sets flag if bit 0 set; rising if bit 1 set.
package zcdc_pkg;
    // Register map, word offsets on the plain port
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_INT_CLEAR = 4'h3;
    // Control register fields
    localparam int BIT_SOFT_ENABLE = 7;
    localparam int BIT_OUTPUT_STATE = 5;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_RISE_ENABLE = 1;
    localparam int BIT_FALL_ENABLE = 0;
    // Writable control bits; unimplemented and read-only bits excluded
    localparam logic [7:0] CONTROL_WMASK = 8'h93;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Status register fields
    localparam int BIT_ZC_FLAG = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : zcdc_pkg

//--- verilog/zcdc_top.sv
`timescale 1ns/1ps
module zcdc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Analog front end and fuse
    input wire logic zc_pin_sinking,
    input wire logic zc_fuse_enable,
    output logic zc_detector_on,
    output logic zc_logic_output,
    // Interrupt
    output logic zc_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by the write strobes
    // Strobe and address qualify together; an address alone never writes
    function automatic logic bus_hit(
        input logic strobe,
        input logic [3:0] addr,
        input logic [3:0] target
    );
        bus_hit = strobe && (addr == target);
    endfunction : bus_hit

    ////////////////////////////////////////////////////////////////////////
    // Control register and named views of its fields
    logic [7:0] zero_cross_control;
    logic [7:0] next_zero_cross_control;
    logic zc_soft_enable;
    logic zc_polarity_invert;
    logic zc_rise_flag_enable;
    logic zc_fall_flag_enable;
    // Interrupt enable, sticky flag and level output
    logic int_enable;
    logic next_int_enable;
    logic zc_interrupt_flag;
    logic next_zc_interrupt_flag;
    logic next_irq;
    logic flag_set;
    logic flag_clear;
    // Detector path and edge history
    logic next_detector_on;
    logic next_logic_output;
    logic prev_out;
    logic next_prev_out;
    logic out_valid;
    logic next_out_valid;
    logic rise_evt;
    logic fall_evt;
    // Bus decode and read path
    logic wr_control;
    logic wr_int_enable;
    logic wr_int_clear;
    logic [7:0] next_rdata;

    // Field views keep bit positions in the package only
    assign zc_soft_enable =
        zero_cross_control[zcdc_pkg::BIT_SOFT_ENABLE];
    assign zc_polarity_invert =
        zero_cross_control[zcdc_pkg::BIT_POLARITY];
    assign zc_rise_flag_enable =
        zero_cross_control[zcdc_pkg::BIT_RISE_ENABLE];
    assign zc_fall_flag_enable =
        zero_cross_control[zcdc_pkg::BIT_FALL_ENABLE];

    // Write decode; the clear register has no storage of its own
    assign wr_control = bus_hit(reg_write, reg_addr,
        zcdc_pkg::ADDR_CONTROL);
    assign wr_int_enable = bus_hit(reg_write, reg_addr,
        zcdc_pkg::ADDR_INT_ENABLE);
    assign wr_int_clear = bus_hit(reg_write, reg_addr,
        zcdc_pkg::ADDR_INT_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // Detector group: enable, polarity and edge history
    // Output held low while off, so switching off can look like a fall
    // Pin taken as synchronous; no extra flops, one cycle of latency
    always_comb begin
        next_detector_on = zc_fuse_enable | zc_soft_enable;
        next_logic_output = next_detector_on &
            (zc_pin_sinking ^ zc_polarity_invert);
        next_prev_out = zc_logic_output;
        // Edges count from the first clock after reset, so the first sample is compared against the reset-zero history
        next_out_valid = 1'b1;
    end

    // Detector flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zc_detector_on <= 1'b0;
            zc_logic_output <= 1'b0;
            prev_out <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            zc_detector_on <= next_detector_on;
            zc_logic_output <= next_logic_output;
            prev_out <= next_prev_out;
            out_valid <= next_out_valid;
        end
    end

    // Edges between two registered samples of the output
    assign rise_evt = out_valid & zc_logic_output & ~prev_out;
    assign fall_evt = out_valid & ~zc_logic_output & prev_out;

    ////////////////////////////////////////////////////////////////////////
    // Register group: control and interrupt enable
    // Writes land on the edge that samples the strobe
    always_comb begin
        next_zero_cross_control = zero_cross_control;
        next_int_enable = int_enable;
        if (wr_control) begin
            // Status bit is not stored, so writes cannot touch it
            next_zero_cross_control =
                reg_wdata & zcdc_pkg::CONTROL_WMASK;
        end
        if (wr_int_enable) begin
            next_int_enable = reg_wdata[zcdc_pkg::BIT_ZC_FLAG];
        end
    end

    // Register flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zero_cross_control <= zcdc_pkg::CONTROL_RESET;
            int_enable <= 1'b0;
        end else begin
            zero_cross_control <= next_zero_cross_control;
            int_enable <= next_int_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag group: sticky flag and level interrupt
    // An enabled edge, and the clear bit of a clear write
    assign flag_set = (rise_evt & zc_rise_flag_enable) |
        (fall_evt & zc_fall_flag_enable);
    assign flag_clear = wr_int_clear & reg_wdata[zcdc_pkg::BIT_ZC_FLAG];

    // Set placed after clear so a coincident edge is never lost
    always_comb begin
        next_zc_interrupt_flag = zc_interrupt_flag;
        if (flag_clear) begin
            next_zc_interrupt_flag = 1'b0;
        end
        if (flag_set) begin
            next_zc_interrupt_flag = 1'b1;
        end
        // From next values so the level tracks the flag without lag
        next_irq = next_zc_interrupt_flag & next_int_enable;
    end

    // Flag and interrupt flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zc_interrupt_flag <= 1'b0;
            zc_irq <= 1'b0;
        end else begin
            zc_interrupt_flag <= next_zc_interrupt_flag;
            zc_irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read group; data stands one cycle after the strobe, zero otherwise
    // Unmapped addresses and the write-only clear read back zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                zcdc_pkg::ADDR_CONTROL: begin
                    next_rdata = zero_cross_control;
                    next_rdata[zcdc_pkg::BIT_OUTPUT_STATE] =
                        zc_logic_output;
                end
                zcdc_pkg::ADDR_STATUS: begin
                    next_rdata[zcdc_pkg::BIT_ZC_FLAG] = zc_interrupt_flag;
                end
                zcdc_pkg::ADDR_INT_ENABLE: begin
                    next_rdata[zcdc_pkg::BIT_ZC_FLAG] = int_enable;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Read data flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks: status bit, control writes and the read path
    // Read data is registered, so it must match the strobe cycle's output
    AST_STATUS_READ: assert property (@(posedge clk)
        disable iff (!nrst)
        bus_hit(reg_read, reg_addr, zcdc_pkg::ADDR_CONTROL) |=>
        reg_rdata[zcdc_pkg::BIT_OUTPUT_STATE] == $past(zc_logic_output))
        else $error("status bit does not follow output");

    // Only writable bits may land; status and unused bits stay clear
    AST_CONTROL_WRITE: assert property (@(posedge clk)
        disable iff (!nrst)
        wr_control |=> zero_cross_control ==
        ($past(reg_wdata) & zcdc_pkg::CONTROL_WMASK))
        else $error("control write not masked");

    // Bits 6, 3 and 2, unused in control, read zero on every register
    AST_RSVD_ZERO: assert property (@(posedge clk)
        disable iff (!nrst)
        $past(reg_read) |-> reg_rdata[6] == 1'b0 &&
        reg_rdata[3:2] == 2'b00)
        else $error("unimplemented bits not zero");

    // Data stands one cycle only; a stale word would be read twice
    AST_RDATA_IDLE: assert property (@(posedge clk)
        disable iff (!nrst)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not cleared after strobe");

    ////////////////////////////////////////////////////////////////////////
    // Checks: enable, fuse override and polarity
    // Detector forced on by the fuse whatever software wrote
    AST_FUSE_ON: assert property (@(posedge clk)
        disable iff (!nrst)
        zc_fuse_enable |=> zc_detector_on)
        else $error("fuse did not force detector on");

    // With neither fuse nor soft enable the detector and output stay low
    AST_SOFT_OFF: assert property (@(posedge clk)
        disable iff (!nrst)
        !zc_fuse_enable && !zc_soft_enable |=>
        !zc_detector_on && !zc_logic_output)
        else $error("detector on without an enable");

    // Polarity clear: output follows the sinking state of the pin
    AST_NOINV: assert property (@(posedge clk)
        disable iff (!nrst)
        !zc_polarity_invert && (zc_fuse_enable || zc_soft_enable) |=>
        zc_logic_output == $past(zc_pin_sinking))
        else $error("non-inverted output wrong");

    // Polarity set: output is the inverse of the sinking state
    AST_INV: assert property (@(posedge clk)
        disable iff (!nrst)
        zc_polarity_invert && (zc_fuse_enable || zc_soft_enable) |=>
        zc_logic_output == !$past(zc_pin_sinking))
        else $error("inverted output wrong");

    ////////////////////////////////////////////////////////////////////////
    // Checks: edge selection, sticky flag and interrupt level
    AST_RISE_SET: assert property (@(posedge clk)
        disable iff (!nrst)
        rise_evt && zc_rise_flag_enable |=> zc_interrupt_flag)
        else $error("rising edge did not set flag");

    AST_FALL_SET: assert property (@(posedge clk)
        disable iff (!nrst)
        fall_evt && zc_fall_flag_enable |=> zc_interrupt_flag)
        else $error("falling edge did not set flag");

    // A disabled edge leaves the flag alone
    AST_NO_SPURIOUS: assert property (@(posedge clk)
        disable iff (!nrst)
        !zc_interrupt_flag && !(rise_evt && zc_rise_flag_enable) &&
        !(fall_evt && zc_fall_flag_enable) |=> !zc_interrupt_flag)
        else $error("flag set without enabled edge");

    // A clear write empties the flag unless an enabled edge lands with it
    AST_CLEAR: assert property (@(posedge clk)
        disable iff (!nrst)
        wr_int_clear && reg_wdata[zcdc_pkg::BIT_ZC_FLAG] &&
        !(rise_evt && zc_rise_flag_enable) &&
        !(fall_evt && zc_fall_flag_enable) |=> !zc_interrupt_flag)
        else $error("clear write did not clear flag");

    // Level output registered from the same next values as the flag
    AST_IRQ: assert property (@(posedge clk)
        disable iff (!nrst)
        zc_irq == (zc_interrupt_flag && int_enable))
        else $error("interrupt level mismatch");

    ////////////////////////////////////////////////////////////////////////
    // Main scenarios worth seeing at least once
    COV_RISE: cover property (@(posedge clk) disable iff (!nrst)
        rise_evt && zc_rise_flag_enable);
    COV_FALL: cover property (@(posedge clk) disable iff (!nrst)
        fall_evt && zc_fall_flag_enable);
    COV_IRQ: cover property (@(posedge clk) disable iff (!nrst) zc_irq);
    // Clear and set in one cycle; the set must win
    COV_CLR_SET: cover property (@(posedge clk) disable iff (!nrst)
        flag_clear && flag_set);
    // Fuse holding the detector on against a cleared software bit
    COV_FUSE_OVERRIDE: cover property (@(posedge clk) disable iff (!nrst)
        zc_fuse_enable && !zc_soft_enable && zc_logic_output);

endmodule : zcdc_top
